// ==== hdl/irpm_top.sv ====
// pid-based protection and page translation for the on-chip rams
`timescale 1ns/10ps
`include "irpm_defs.svh"
module irpm_top #(
  parameter int PAGES = 16
) (
  input  wire logic               clk_sys_i,
  input  wire logic               arst_n_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [2:0]         reg_pid_i,
  output logic      [31:0]        reg_rdata_o,
  input  irpm_pkg::irpm_req_t     ibus_req_i,
  output irpm_pkg::irpm_rsp_t     ibus_rsp_o,
  input  irpm_pkg::irpm_req_t     dbus_req_i,
  output irpm_pkg::irpm_rsp_t     dbus_rsp_o
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [7:0]            fast_rtc_mem_pid_allow_q;
  logic [5:0]            slow_rtc_mem_pid_allow_q;
  irpm_pkg::irpm_psize_t instr_ram_page_size_sel_q;
  irpm_pkg::irpm_psize_t data_ram_page_size_sel_q;
  logic                  os_pid;
  logic                  i_map_sel;
  logic                  d_map_sel;
  logic [PAGES*7-1:0]    i_map_all;
  logic [PAGES*7-1:0]    d_map_all;
  logic [6:0]            i_map_rd;
  logic [6:0]            d_map_rd;
  logic [1:0]            rd_src_q;
  logic [31:0]           rd_reg_q;

  function automatic logic is_os(input logic [2:0] pid);
    return pid == 3'h0 || pid == 3'h1;
  endfunction

  assign os_pid    = is_os(reg_pid_i);
  assign i_map_sel = reg_addr_i[7:6] == `IRPM_OFS_I_MAP0 >> 6;
  assign d_map_sel = reg_addr_i[7:6] == `IRPM_OFS_D_MAP0 >> 6;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fast_rtc_mem_pid_allow_q <= `IRPM_RST_FAST_ALLOW;
    end else if (reg_wr_i && reg_addr_i == `IRPM_OFS_FAST_ALLOW && reg_pid_i == 3'h0) begin
      fast_rtc_mem_pid_allow_q <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slow_rtc_mem_pid_allow_q <= `IRPM_RST_SLOW_ALLOW;
    end else if (reg_wr_i && reg_addr_i == `IRPM_OFS_SLOW_ALLOW && os_pid) begin
      slow_rtc_mem_pid_allow_q <= reg_wdata_i[5:0];
    end
  end

  // codes above 2 are not stored; the field keeps its old size
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instr_ram_page_size_sel_q <= irpm_pkg::irpm_psize_t'(`IRPM_RST_PSIZE);
      data_ram_page_size_sel_q  <= irpm_pkg::irpm_psize_t'(`IRPM_RST_PSIZE);
    end else if (reg_wr_i && os_pid && reg_wdata_i[1:0] != 2'h3) begin
      if (reg_addr_i == `IRPM_OFS_I_PSIZE) begin
        instr_ram_page_size_sel_q <= irpm_pkg::irpm_psize_t'(reg_wdata_i[1:0]);
      end
      if (reg_addr_i == `IRPM_OFS_D_PSIZE) begin
        data_ram_page_size_sel_q <= irpm_pkg::irpm_psize_t'(reg_wdata_i[1:0]);
      end
    end
  end

  // one map store per unit, indexed by physical page
  irpm_map_mem #(.DEPTH(PAGES)) u_imap (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (reg_wr_i && i_map_sel && os_pid),
    .wr_idx_i  (reg_addr_i[5:2]),
    .wr_data_i (reg_wdata_i[6:0]),
    .rd_idx_i  (reg_addr_i[5:2]),
    .rd_data_o (i_map_rd),
    .all_o     (i_map_all)
  );

  irpm_map_mem #(.DEPTH(PAGES)) u_dmap (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (reg_wr_i && d_map_sel && os_pid),
    .wr_idx_i  (reg_addr_i[5:2]),
    .wr_data_i (reg_wdata_i[6:0]),
    .rd_idx_i  (reg_addr_i[5:2]),
    .rd_data_o (d_map_rd),
    .all_o     (d_map_all)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register read: data in the cycle after the strobe, zero when unmapped
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_src_q <= 2'h0;
      rd_reg_q <= 32'h0;
    end else begin
      rd_src_q <= 2'h0;
      rd_reg_q <= 32'h0;
      if (reg_rd_i) begin
        if (i_map_sel) begin
          rd_src_q <= 2'h1;
        end else if (d_map_sel) begin
          rd_src_q <= 2'h2;
        end
        unique case (reg_addr_i)
          `IRPM_OFS_FAST_ALLOW: rd_reg_q <= {24'h0, fast_rtc_mem_pid_allow_q};
          `IRPM_OFS_SLOW_ALLOW: rd_reg_q <= {26'h0, slow_rtc_mem_pid_allow_q};
          `IRPM_OFS_I_PSIZE:    rd_reg_q <= {30'h0, instr_ram_page_size_sel_q};
          `IRPM_OFS_D_PSIZE:    rd_reg_q <= {30'h0, data_ram_page_size_sel_q};
          default:              rd_reg_q <= 32'h0;
        endcase
      end
    end
  end

  always_comb begin
    unique case (rd_src_q)
      2'h1:    reg_rdata_o = {25'h0, i_map_rd};
      2'h2:    reg_rdata_o = {25'h0, d_map_rd};
      default: reg_rdata_o = rd_reg_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // access decision and translation
  function automatic logic rights_grant(input logic [2:0] rights, input logic [2:0] pid);
    return rights == `IRPM_RIGHTS_ALL || (rights != `IRPM_RIGHTS_NONE && rights == pid);
  endfunction

  function automatic logic [1:0] psize_shift(input irpm_pkg::irpm_psize_t ps);
    unique case (ps)
      irpm_pkg::IRPM_PS_4K: return 2'h1;
      irpm_pkg::IRPM_PS_2K: return 2'h2;
      default:              return 2'h0;
    endcase
  endfunction

  // returns {deny, translated address}
  function automatic logic [32:0] mmu_xlate(input logic [31:0] addr,
                                            input logic [2:0] pid,
                                            input irpm_pkg::irpm_psize_t ps,
                                            input logic [PAGES*7-1:0] maps);
    logic [16:0] ofs;
    logic [1:0]  sh;
    logic [3:0]  vpg;
    logic [12:0] inpg;
    logic        hit;
    logic [3:0]  ppg;
    irpm_pkg::irpm_map_t ent;
    ofs  = addr[16:0];
    sh   = psize_shift(ps);
    hit  = 1'b0;
    ppg  = 4'h0;
    vpg  = 4'(ofs >> (13 - sh));
    inpg = 13'(ofs & (17'h1FFF >> sh));
    if (is_os(pid)) begin
      return {1'b0, addr};
    end
    if ((ofs >> (13 - sh)) > 17'hF) begin
      return {1'b1, addr};
    end
    for (int p = 0; p < PAGES; p++) begin
      ent = maps[p*7 +: 7];
      if (!hit && ent.vpage == vpg && rights_grant(ent.rights, pid)) begin
        hit = 1'b1;
        ppg = 4'(p);
      end
    end
    if (!hit) begin
      return {1'b1, addr};
    end
    return {1'b0, addr[31:17], 17'((17'(ppg) << (13 - sh)) | 17'(inpg))};
  endfunction

  function automatic logic rtc_deny(input logic [31:0] addr, input logic [2:0] pid,
                                    input logic [7:0] fa, input logic [5:0] sa);
    logic [31:0] pg;
    pg = addr & `IRPM_RTC_MASK;
    if (pg == `IRPM_FAST_BASE || pg == `IRPM_FAST_ALIAS) begin
      return !fa[pid];
    end
    if (pg == `IRPM_SLOW_BASE) begin
      if (is_os(pid)) begin
        return 1'b0;
      end
      return !sa[3'(pid - 3'h2)];
    end
    return 1'b0;
  endfunction

  function automatic irpm_pkg::irpm_rsp_t check(input irpm_pkg::irpm_req_t rq,
                                                input logic [31:0] base,
                                                input irpm_pkg::irpm_psize_t ps,
                                                input logic [PAGES*7-1:0] maps,
                                                input logic [7:0] fa,
                                                input logic [5:0] sa);
    irpm_pkg::irpm_rsp_t rs;
    logic [32:0]         xl;
    rs.valid = rq.valid;
    rs.write = rq.write;
    rs.addr  = rq.addr;
    rs.deny  = 1'b0;
    xl       = 33'h0;
    if ((rq.addr & `IRPM_MMU_MASK) == base) begin
      xl      = mmu_xlate(rq.addr, rq.pid, ps, maps);
      rs.deny = xl[32];
      rs.addr = xl[31:0];
    end else begin
      rs.deny = rtc_deny(rq.addr, rq.pid, fa, sa);
    end
    return rs;
  endfunction

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ibus_rsp_o <= '0;
    end else begin
      ibus_rsp_o <= check(ibus_req_i, `IRPM_I_BASE, instr_ram_page_size_sel_q, i_map_all,
                          fast_rtc_mem_pid_allow_q, slow_rtc_mem_pid_allow_q);
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbus_rsp_o <= '0;
    end else begin
      dbus_rsp_o <= check(dbus_req_i, `IRPM_D_BASE, data_ram_page_size_sel_q, d_map_all,
                          fast_rtc_mem_pid_allow_q, slow_rtc_mem_pid_allow_q);
    end
  end
endmodule

// ==== hdl/irpm_defs.svh ====
// register map, field layout and address constants for the internal ram pid protection block
// What this block does
// - fast and slow memory access allowed when that pid's allow bit is one
// - pids 0 and 1 always reach slow memory
// - fast allow bit n is pid n; slow allow bits 0..5 are pids 2..7
// - fast allow register takes writes only from pid 0
// - slow allow register takes writes only from pid 0 or 1
// - each translation unit splits the upper 128 KB into 16 pages
// - page size code 0 is 8 KB, 1 is 4 KB, 2 is 2 KB
// - uncovered remainder reachable only by pids 0 and 1
// - pids 0 and 1 map page x to page x, always allowed
// - pids 2..7 go to the mapped physical page, offset kept
// - page n spans base plus size times n; bases fixed per side
// - sixteen map registers per unit, indexed by physical page
// - rights 0 none, 1 all, 2..7 only that pid
// - four-bit field names the virtual page mapped here
// - map and page size registers written only by pid 0 or 1
`ifndef IRPM_DEFS_SVH
`define IRPM_DEFS_SVH

`define IRPM_ADDR_W          8
`define IRPM_OFS_FAST_ALLOW  8'h00
`define IRPM_OFS_SLOW_ALLOW  8'h04
`define IRPM_OFS_I_PSIZE     8'h08
`define IRPM_OFS_D_PSIZE     8'h0C
`define IRPM_OFS_I_MAP0      8'h40
`define IRPM_OFS_D_MAP0      8'h80
`define IRPM_MAP_SPAN        8'h40
`define IRPM_RST_FAST_ALLOW  8'h00
`define IRPM_RST_SLOW_ALLOW  6'h00
`define IRPM_RST_PSIZE       2'h0
`define IRPM_RST_MAP         7'h00
`define IRPM_I_BASE          32'h40080000
`define IRPM_D_BASE          32'h3FFC0000
`define IRPM_FAST_BASE       32'h3FF80000
`define IRPM_FAST_ALIAS      32'h400C0000
`define IRPM_SLOW_BASE       32'h50000000
`define IRPM_RTC_MASK        32'hFFFFE000
`define IRPM_MMU_MASK        32'hFFFE0000
`define IRPM_RIGHTS_MSB      6
`define IRPM_RIGHTS_LSB      4
`define IRPM_VPAGE_MSB       3
`define IRPM_VPAGE_LSB       0
`define IRPM_RIGHTS_NONE     3'h0
`define IRPM_RIGHTS_ALL      3'h1

`endif

// ==== hdl/irpm_pkg.sv ====
// types shared by the internal ram pid protection block
package irpm_pkg;
  typedef logic [2:0] irpm_pid_t;

  typedef enum logic [1:0] {
    IRPM_PS_8K = 2'h0,
    IRPM_PS_4K = 2'h1,
    IRPM_PS_2K = 2'h2
  } irpm_psize_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    irpm_pid_t   pid;
  } irpm_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        deny;
    logic [31:0] addr;
  } irpm_rsp_t;

  typedef struct packed {
    logic [2:0] rights;
    logic [3:0] vpage;
  } irpm_map_t;
endpackage

// ==== hdl/irpm_map_mem.sv ====
// sixteen-entry page map store with registered read port
`timescale 1ns/10ps
`include "irpm_defs.svh"
module irpm_map_mem #(
  parameter int DEPTH = 16
) (
  input  wire logic               clk_sys_i,
  input  wire logic               arst_n_i,
  input  wire logic               wr_en_i,
  input  wire logic [3:0]         wr_idx_i,
  input  wire logic [6:0]         wr_data_i,
  input  wire logic [3:0]         rd_idx_i,
  output logic      [6:0]         rd_data_o,
  output logic      [DEPTH*7-1:0] all_o
);
  logic [6:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `IRPM_RST_MAP;
      end
    end else if (wr_en_i) begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= `IRPM_RST_MAP;
    end else begin
      rd_data_o <= mem_q[rd_idx_i];
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_o[i*7 +: 7] = mem_q[i];
    end
  end
endmodule

// ==== testbench/irpm_checker.sv ====
// port-level assertions for the ram protection block
`timescale 1ns/10ps
`include "irpm_defs.svh"
module irpm_checker #(
  parameter int PAGES = 16
) (
  input wire logic           clk_sys_i,
  input wire logic           arst_n_i,
  input wire logic [7:0]     reg_addr_i,
  input wire logic [31:0]    reg_wdata_i,
  input wire logic           reg_wr_i,
  input wire logic           reg_rd_i,
  input wire logic [2:0]     reg_pid_i,
  input wire logic [31:0]    reg_rdata_o,
  input irpm_pkg::irpm_req_t ibus_req_i,
  input irpm_pkg::irpm_rsp_t ibus_rsp_o,
  input irpm_pkg::irpm_req_t dbus_req_i,
  input irpm_pkg::irpm_rsp_t dbus_rsp_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ireg;
    ibus_req_i.valid && (ibus_req_i.addr & `IRPM_MMU_MASK) == `IRPM_I_BASE;
  endsequence
  sequence s_dreg;
    dbus_req_i.valid && (dbus_req_i.addr & `IRPM_MMU_MASK) == `IRPM_D_BASE;
  endsequence
  property p_ival;
    ibus_rsp_o.valid == $past(ibus_req_i.valid) && ibus_rsp_o.write == $past(ibus_req_i.write);
  endproperty
  property p_dval;
    dbus_rsp_o.valid == $past(dbus_req_i.valid) && dbus_rsp_o.write == $past(dbus_req_i.write);
  endproperty
  property p_i01;
    s_ireg ##0 ibus_req_i.pid < 3'h2 |=>
      !ibus_rsp_o.deny && ibus_rsp_o.addr == $past(ibus_req_i.addr);
  endproperty
  property p_d01;
    s_dreg ##0 dbus_req_i.pid < 3'h2 |=>
      !dbus_rsp_o.deny && dbus_rsp_o.addr == $past(dbus_req_i.addr);
  endproperty
  // translation keeps the low 11 bits of the page offset and stays inside the region
  property p_ioff;
    s_ireg |=> ibus_rsp_o.deny || ((ibus_rsp_o.addr ^ $past(ibus_req_i.addr)) & 32'hFFFE07FF) == 0;
  endproperty
  property p_doff;
    s_dreg |=> dbus_rsp_o.deny || ((dbus_rsp_o.addr ^ $past(dbus_req_i.addr)) & 32'hFFFE07FF) == 0;
  endproperty
  property p_slow;
    dbus_req_i.valid && dbus_req_i.pid < 3'h2 &&
      (dbus_req_i.addr & `IRPM_RTC_MASK) == `IRPM_SLOW_BASE |=> !dbus_rsp_o.deny;
  endproperty
  property p_rdz;
    !reg_rd_i |=> reg_rdata_o == 32'h0;
  endproperty
  a_ival: assert property (p_ival) else $error("ibus valid or write not passed on");
  a_dval: assert property (p_dval) else $error("dbus valid or write not passed on");
  a_i01: assert property (p_i01) else $error("ibus privileged access altered");
  a_d01: assert property (p_d01) else $error("dbus privileged access altered");
  a_ioff: assert property (p_ioff) else $error("ibus offset or region lost");
  a_doff: assert property (p_doff) else $error("dbus offset or region lost");
  a_slow: assert property (p_slow) else $error("slow memory refused to pid 0 or 1");
  a_rdz: assert property (p_rdz) else $error("read data outside read slot");
endmodule
bind irpm_top irpm_checker #(.PAGES(PAGES)) u_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_pid_i(reg_pid_i), .reg_rdata_o(reg_rdata_o), .ibus_req_i(ibus_req_i),
  .ibus_rsp_o(ibus_rsp_o), .dbus_req_i(dbus_req_i), .dbus_rsp_o(dbus_rsp_o));

// ==== testbench/irpm_cpu_model.sv ====
// cpu side requester: puts bench requests on the two buses one edge later
`timescale 1ns/10ps
module irpm_cpu_model (
  input  wire logic           clk_sys_i,
  input  wire logic           arst_n_i,
  input  irpm_pkg::irpm_req_t icmd_i,
  input  irpm_pkg::irpm_req_t dcmd_i,
  output irpm_pkg::irpm_req_t ibus_req_o,
  output irpm_pkg::irpm_req_t dbus_req_o
);
  // between requests the lines carry a changing pattern, not the last request
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ibus_req_o <= '0;
      dbus_req_o <= '0;
    end else begin
      ibus_req_o <= icmd_i.valid ? icmd_i : irpm_pkg::irpm_req_t'({1'b0, ~ibus_req_o[35:0]});
      dbus_req_o <= dcmd_i.valid ? dcmd_i : irpm_pkg::irpm_req_t'({1'b0, ~dbus_req_o[35:0]});
    end
  end
endmodule

// ==== testbench/irpm_top_test.sv ====
// self-checking bench for register rights and bus translation
`timescale 1ns/10ps
`include "irpm_defs.svh"
module irpm_top_test;
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  logic [7:0]          reg_addr = 8'h00;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [2:0]          reg_pid = 3'h0;
  logic [31:0]         reg_rdata;
  irpm_pkg::irpm_req_t icmd = '0;
  irpm_pkg::irpm_req_t dcmd = '0;
  irpm_pkg::irpm_req_t ibus_req;
  irpm_pkg::irpm_req_t dbus_req;
  irpm_pkg::irpm_rsp_t ibus_rsp;
  irpm_pkg::irpm_rsp_t dbus_rsp;
  logic [31:0]         seed = 32'h04EBBA30;
  logic [7:0]          fa = 8'h00;
  logic [5:0]          sa = 6'h00;
  logic [1:0]          ips = 2'h0;
  logic [1:0]          dps = 2'h0;
  logic [6:0]          imap [16] = '{default: 7'h00};
  logic [6:0]          dmap [16] = '{default: 7'h00};
  logic [31:0]         r;
  int                  failures = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  irpm_cpu_model cpu (.clk_sys_i(clk), .arst_n_i(arst_n), .icmd_i(icmd), .dcmd_i(dcmd),
    .ibus_req_o(ibus_req), .dbus_req_o(dbus_req));
  irpm_top #(.PAGES(16)) uut (.clk_sys_i(clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_pid_i(reg_pid),
    .reg_rdata_o(reg_rdata), .ibus_req_i(ibus_req), .ibus_rsp_o(ibus_rsp),
    .dbus_req_i(dbus_req), .dbus_rsp_o(dbus_rsp));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] rexp(input logic [7:0] a);
    if (a[7:6] == 2'h1) return {25'h0, imap[a[5:2]]};
    if (a[7:6] == 2'h2) return {25'h0, dmap[a[5:2]]};
    if (a == 8'h00) return {24'h0, fa};
    if (a == 8'h04) return {26'h0, sa};
    if (a == 8'h08) return {30'h0, ips};
    if (a == 8'h0C) return {30'h0, dps};
    return 32'h0;
  endfunction
  // deny flag above the expected physical address
  function automatic logic [32:0] aexp(input logic i, input logic [31:0] a, input logic [2:0] p);
    logic [31:0] b;
    logic [6:0]  e;
    int          sh;
    b = i ? `IRPM_I_BASE : `IRPM_D_BASE;
    sh = 13 - int'(i ? ips : dps);
    if ((a & `IRPM_RTC_MASK) == `IRPM_FAST_BASE || (a & `IRPM_RTC_MASK) == `IRPM_FAST_ALIAS)
      return {~fa[p], a};
    if ((a & `IRPM_RTC_MASK) == `IRPM_SLOW_BASE) return {p > 3'h1 && !sa[p - 3'h2], a};
    if ((a & `IRPM_MMU_MASK) != b || p < 3'h2) return {1'b0, a};
    if (32'(a[16:0]) >= (32'h1 << (sh + 4))) return {1'b1, a};
    for (int n = 0; n < 16; n++) begin
      e = i ? imap[n] : dmap[n];
      if (e[3:0] == 4'(a[16:0] >> sh) && (e[6:4] == 3'h1 || e[6:4] == p))
        return {1'b0, b + (n << sh) + (a & ((32'h1 << sh) - 32'h1))};
    end
    return {1'b1, a};
  endfunction
  task automatic compare(input string what, input logic [32:0] exp, input logic [32:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_pid <= p;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 8'h00 && p == 3'h0) fa = d[7:0];
    if (a == 8'h04 && p < 3'h2) sa = d[5:0];
    if (a == 8'h08 && p < 3'h2 && d[1:0] != 2'h3) ips = d[1:0];
    if (a == 8'h0C && p < 3'h2 && d[1:0] != 2'h3) dps = d[1:0];
    if (a[7:6] == 2'h1 && p < 3'h2) imap[a[5:2]] = d[6:0];
    if (a[7:6] == 2'h2 && p < 3'h2) dmap[a[5:2]] = d[6:0];
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    compare("register read", {1'b0, rexp(a)}, {1'b0, reg_rdata});
  endtask
  task automatic acc(input logic [31:0] ai, input logic [31:0] ad, input logic [5:0] p);
    logic [32:0] ei;
    logic [32:0] ed;
    ei = aexp(1'b1, ai, p[2:0]);
    ed = aexp(1'b0, ad, p[5:3]);
    @(posedge clk);
    icmd <= '{1'b1, p[0], ai, p[2:0]};
    dcmd <= '{1'b1, p[3], ad, p[5:3]};
    @(posedge clk);
    icmd.valid <= 1'b0;
    dcmd.valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    compare("ibus response", {ei[32], ei[32] ? 32'h0 : ei[31:0]},
      {ibus_rsp.deny, ei[32] ? 32'h0 : ibus_rsp.addr});
    compare("dbus response", {ed[32], ed[32] ? 32'h0 : ed[31:0]},
      {dbus_rsp.deny, ed[32] ? 32'h0 : dbus_rsp.addr});
  endtask
  function automatic logic [31:0] pick(input logic [31:0] b, input logic [31:0] x);
    case (x[31:29])
      3'h3: return `IRPM_FAST_BASE + {19'h0, x[12:0]};
      3'h4: return `IRPM_FAST_ALIAS + {19'h0, x[12:0]};
      3'h5: return `IRPM_SLOW_BASE + {19'h0, x[12:0]};
      3'h6: return 32'h60000000 + {16'h0, x[15:0]};
      3'h7: return b + 32'h0001FFFF;
      default: return b + {15'h0, x[16:0]};
    endcase
  endfunction
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    for (int n = 0; n < 64; n++) rd(8'(n * 4));
    $display("reset and unmapped reads done");
    for (int p = 0; p < 8; p++) begin
      foreach (r[k]) if (k < 6) wr(k < 4 ? 8'(k * 4) : 8'(k * 64 - 192), rnd(), 3'(p));
      for (int k = 0; k < 6; k++) rd(k < 4 ? 8'(k * 4) : 8'(k * 64 - 192));
    end
    $display("write permission sweep done");
    wr(8'h0C, 32'h0, 3'h0);
    wr(8'h88, 32'h11, 3'h1);
    wr(8'h08, 32'h2, 3'h0);
    acc(32'h4009FFFF, 32'h3FFC2345, 6'h12);
    $display("translation example done");
    repeat (600) begin
      r = rnd();
      if (r[0])
        wr(r[4] ? {r[5], ~r[5], r[9:6], 2'h0} : {4'h0, r[6:5], 2'h0}, rnd(),
          r[10] ? r[13:11] : {2'h0, r[11]});
      else
        acc(pick(`IRPM_I_BASE, rnd()), pick(`IRPM_D_BASE, rnd()), r[17:12]);
    end
    $display("random traffic done");
    close_out();
  end
endmodule
